//--- hw/cbrs_pkg.sv
package cbrs_pkg;

   // Clock and data of one two-wire pair
   typedef struct packed {
      logic clock;
      logic data;
   } cbrs_pair_t;

   typedef enum logic [1:0] {
      RT_ROM,
      RT_REG,
      RT_DDC
   } cbrs_route_t;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_A,
      ST_SUB,
      ST_ACK_S,
      ST_WDATA,
      ST_ACK_W,
      ST_RDATA,
      ST_RACK
   } cbrs_bus_st_t;

endpackage

//--- hw/cbrs_regs.svh
`ifndef CBRS_REGS_SVH
`define CBRS_REGS_SVH

// ==========================================================
// Device addresses of the internal register file (8-bit form)
`define CBRS_DEV_ADDR_A 8'h70
`define CBRS_DEV_ADDR_B 8'h72

// ==========================================================
// Register file layout
`define CBRS_OPC_FIRST 8'h00
`define CBRS_OPC_LAST 8'h11
`define CBRS_OPC_COUNT 18
`define CBRS_ROUTE_IDX 8'h10
`define CBRS_ROUTE_ROM 8'h01
`define CBRS_ROUTE_DDC 8'h02
`define CBRS_REG_RESET 8'h00

// ==========================================================
// Echo guard count in mclk cycles, and bits per serial byte
`define CBRS_ECHO_GUARD 3'h4
`define CBRS_BYTE_BITS 4'h8

`endif

//--- hw/cbrs_switch.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbrs_regs.svh"

module cbrs_switch (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire cbrs_pkg::cbrs_pair_t ctrl_serial_in,
   output cbrs_pkg::cbrs_pair_t ctrl_serial_out,
   output cbrs_pkg::cbrs_pair_t ctrl_serial_oe,
   input wire cbrs_pkg::cbrs_pair_t card_rom_in,
   output cbrs_pkg::cbrs_pair_t card_rom_out,
   output cbrs_pkg::cbrs_pair_t card_rom_oe,
   input wire cbrs_pkg::cbrs_pair_t monitor_bus_in,
   output cbrs_pkg::cbrs_pair_t monitor_bus_out,
   output cbrs_pkg::cbrs_pair_t monitor_bus_oe,
   output cbrs_pkg::cbrs_route_t route
);

   // ==========================================================
   // Input synchronisers: index 0 clock, 1 data; ctrl, rom, ddc
   logic [5:0] raw_in;
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] sync3_q;
   logic [5:0] filt_q;
   logic [5:0] prev_q;

   assign raw_in = {monitor_bus_in.data, monitor_bus_in.clock,
                    card_rom_in.data, card_rom_in.clock,
                    ctrl_serial_in.data, ctrl_serial_in.clock};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               sync1_q[gi] <= 1'b1;
               sync2_q[gi] <= 1'b1;
               sync3_q[gi] <= 1'b1;
               filt_q[gi] <= 1'b1;
               prev_q[gi] <= 1'b1;
            end else begin
               sync1_q[gi] <= raw_in[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               // A level counts only once two stages agree
               if (sync2_q[gi] == sync3_q[gi]) begin
                  filt_q[gi] <= sync3_q[gi];
               end
               prev_q[gi] <= filt_q[gi];
            end
         end
      end
   endgenerate

   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic sda_f;

   assign sda_f = filt_q[1];
   assign scl_rise = filt_q[0] & ~prev_q[0];
   assign scl_fall = ~filt_q[0] & prev_q[0];
   assign start_ev = filt_q[0] & prev_q[0] & prev_q[1] & ~filt_q[1];
   assign stop_ev = filt_q[0] & prev_q[0] & ~prev_q[1] & filt_q[1];

   // ==========================================================
   // Register file and bus slave
   cbrs_pkg::cbrs_route_t route_q;
   cbrs_pkg::cbrs_bus_st_t st_q;
   logic [7:0] regs_q [0:`CBRS_OPC_COUNT-1];
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic [3:0] cnt_q;
   logic rw_q;
   logic nak_q;
   logic slave_sda_q;
   logic [1:0] route_req_q;
   logic seen_start_q;
   logic addr_hit;
   logic ptr_ok;
   logic [7:0] rd_byte;

   assign addr_hit = ({shift_q[7:1], 1'b0} == `CBRS_DEV_ADDR_A) ||
                     ({shift_q[7:1], 1'b0} == `CBRS_DEV_ADDR_B);
   assign ptr_ok = (ptr_q <= `CBRS_OPC_LAST);
   // Reserved locations read back as zero
   assign rd_byte = ptr_ok ? regs_q[ptr_q[4:0]] : 8'h00;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= cbrs_pkg::ST_IDLE;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         cnt_q <= 4'h0;
         rw_q <= 1'b0;
         nak_q <= 1'b0;
         slave_sda_q <= 1'b0;
      end else if (start_ev) begin
         st_q <= cbrs_pkg::ST_ADDR;
         cnt_q <= 4'h0;
         slave_sda_q <= 1'b0;
      end else if (stop_ev) begin
         st_q <= cbrs_pkg::ST_IDLE;
         slave_sda_q <= 1'b0;
      end else begin
         unique case (st_q)
            cbrs_pkg::ST_IDLE: begin
            end
            cbrs_pkg::ST_ADDR, cbrs_pkg::ST_SUB, cbrs_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_f};
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == `CBRS_BYTE_BITS) begin
                  cnt_q <= 4'h0;
                  if (st_q == cbrs_pkg::ST_ADDR) begin
                     // Our address is acknowledged unless the monitor owns
                     if (addr_hit && route_q != cbrs_pkg::RT_DDC) begin
                        slave_sda_q <= 1'b1;
                        rw_q <= shift_q[0];
                        st_q <= cbrs_pkg::ST_ACK_A;
                     end else begin
                        st_q <= cbrs_pkg::ST_IDLE;
                     end
                  end else if (st_q == cbrs_pkg::ST_SUB) begin
                     ptr_q <= shift_q;
                     slave_sda_q <= 1'b1;
                     st_q <= cbrs_pkg::ST_ACK_S;
                  end else begin
                     ptr_q <= ptr_q + 8'h01;
                     slave_sda_q <= 1'b1;
                     st_q <= cbrs_pkg::ST_ACK_W;
                  end
               end
            end
            cbrs_pkg::ST_ACK_A: begin
               if (scl_fall) begin
                  if (rw_q) begin
                     slave_sda_q <= ~rd_byte[7];
                     tx_q <= {rd_byte[6:0], 1'b0};
                     ptr_q <= ptr_q + 8'h01;
                     st_q <= cbrs_pkg::ST_RDATA;
                  end else begin
                     slave_sda_q <= 1'b0;
                     st_q <= cbrs_pkg::ST_SUB;
                  end
               end
            end
            cbrs_pkg::ST_ACK_S, cbrs_pkg::ST_ACK_W: begin
               if (scl_fall) begin
                  slave_sda_q <= 1'b0;
                  st_q <= cbrs_pkg::ST_WDATA;
               end
            end
            cbrs_pkg::ST_RDATA: begin
               if (scl_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == `CBRS_BYTE_BITS) begin
                     cnt_q <= 4'h0;
                     slave_sda_q <= 1'b0;
                     st_q <= cbrs_pkg::ST_RACK;
                  end else begin
                     slave_sda_q <= ~tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                  end
               end
            end
            cbrs_pkg::ST_RACK: begin
               if (scl_rise) begin
                  nak_q <= sda_f;
               end else if (scl_fall) begin
                  if (nak_q) begin
                     st_q <= cbrs_pkg::ST_IDLE;
                  end else begin
                     slave_sda_q <= ~rd_byte[7];
                     tx_q <= {rd_byte[6:0], 1'b0};
                     ptr_q <= ptr_q + 8'h01;
                     st_q <= cbrs_pkg::ST_RDATA;
                  end
               end
            end
         endcase
      end
   end

   // Written only on the serial clock edge that ends a data byte;
   // apart from that only sys_rst touches the array, clearing it to zero
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < `CBRS_OPC_COUNT; i++) begin
            regs_q[i] <= `CBRS_REG_RESET;
         end
      end else if (!start_ev && !stop_ev && scl_fall &&
                   st_q == cbrs_pkg::ST_WDATA &&
                   cnt_q == `CBRS_BYTE_BITS && ptr_ok) begin
         regs_q[ptr_q[4:0]] <= shift_q;
      end
   end

   // ==========================================================
   // Route control
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         route_q <= cbrs_pkg::RT_ROM;
         route_req_q <= 2'h0;
         seen_start_q <= 1'b0;
      end else begin
         // Opcode request is held until the transaction ends
         if (!start_ev && !stop_ev && scl_fall &&
             st_q == cbrs_pkg::ST_WDATA && cnt_q == `CBRS_BYTE_BITS &&
             ptr_q == `CBRS_ROUTE_IDX) begin
            // Any value but the two route codes leaves the route alone
            route_req_q <= (shift_q == `CBRS_ROUTE_ROM) ? 2'h1 :
                           (shift_q == `CBRS_ROUTE_DDC) ? 2'h2 : 2'h0;
         end
         if (start_ev) begin
            seen_start_q <= 1'b1;
         end
         unique case (route_q)
            cbrs_pkg::RT_ROM: begin
               if (!start_ev && !stop_ev && scl_fall &&
                   st_q == cbrs_pkg::ST_ADDR &&
                   cnt_q == `CBRS_BYTE_BITS && addr_hit) begin
                  route_q <= cbrs_pkg::RT_REG;
               end
            end
            cbrs_pkg::RT_REG: begin
               if (stop_ev) begin
                  route_req_q <= 2'h0;
                  seen_start_q <= 1'b0;
                  if (route_req_q == 2'h1) begin
                     route_q <= cbrs_pkg::RT_ROM;
                  end else if (route_req_q == 2'h2) begin
                     route_q <= cbrs_pkg::RT_DDC;
                  end
               end
            end
            cbrs_pkg::RT_DDC: begin
               if (stop_ev) begin
                  seen_start_q <= 1'b0;
                  if (seen_start_q) begin
                     route_q <= cbrs_pkg::RT_REG;
                  end
               end
            end
            default: begin
               route_q <= cbrs_pkg::RT_ROM;
            end
         endcase
      end
   end

   // ==========================================================
   // Pass-through of both lines in both directions
   // After a side lets go, its far line still reads low through the
   // synchroniser; a guard time keeps that stale low from echoing back
   logic [1:0] up_oe_q;
   logic [1:0] rom_oe_q;
   logic [1:0] ddc_oe_q;
   logic [2:0] up_hold_q [0:1];
   logic [2:0] dn_hold_q [0:1];
   logic zero_q;

   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pass
         logic pass;
         logic dn_f;
         logic dn_oe;
         logic dn_drive;
         logic up_drive;
         assign pass = (route_q != cbrs_pkg::RT_REG);
         assign dn_f = (route_q == cbrs_pkg::RT_ROM) ? filt_q[2+gi] :
                       filt_q[4+gi];
         assign dn_oe = rom_oe_q[gi] | ddc_oe_q[gi];
         assign dn_drive = pass & ~filt_q[gi] & ~up_oe_q[gi] &
                           (up_hold_q[gi] == 3'h0);
         assign up_drive = ((gi == 1) & slave_sda_q) |
                           (pass & ~dn_f & ~dn_oe &
                            (dn_hold_q[gi] == 3'h0));
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               up_oe_q[gi] <= 1'b0;
               rom_oe_q[gi] <= 1'b0;
               ddc_oe_q[gi] <= 1'b0;
               up_hold_q[gi] <= 3'h0;
               dn_hold_q[gi] <= 3'h0;
            end else begin
               up_oe_q[gi] <= up_drive;
               rom_oe_q[gi] <= dn_drive & (route_q == cbrs_pkg::RT_ROM);
               ddc_oe_q[gi] <= dn_drive & (route_q == cbrs_pkg::RT_DDC);
               if (up_oe_q[gi] && !up_drive) begin
                  up_hold_q[gi] <= `CBRS_ECHO_GUARD;
               end else if (up_hold_q[gi] != 3'h0) begin
                  up_hold_q[gi] <= up_hold_q[gi] - 3'h1;
               end
               if (dn_oe && !dn_drive) begin
                  dn_hold_q[gi] <= `CBRS_ECHO_GUARD;
               end else if (dn_hold_q[gi] != 3'h0) begin
                  dn_hold_q[gi] <= dn_hold_q[gi] - 3'h1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         zero_q <= 1'b0;
      end else begin
         zero_q <= 1'b0;
      end
   end

   assign ctrl_serial_oe = '{clock: up_oe_q[0], data: up_oe_q[1]};
   assign card_rom_oe = '{clock: rom_oe_q[0], data: rom_oe_q[1]};
   assign monitor_bus_oe = '{clock: ddc_oe_q[0], data: ddc_oe_q[1]};
   assign ctrl_serial_out = '{clock: zero_q, data: zero_q};
   assign card_rom_out = '{clock: zero_q, data: zero_q};
   assign monitor_bus_out = '{clock: zero_q, data: zero_q};
   assign route = route_q;

endmodule // cbrs_switch

`default_nettype wire

//--- verif/cbrs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Controller side of the two-wire bus; it only ever pulls lines low
module cbrs_host_model (
   input wire logic scl,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   // Half a bit period; the caller sets it to suit the route
   int half_ns = 1260;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic start();
      sda_low = 1'b1;
      #60;
      scl_low = 1'b1;
      #30;
   endtask
   // Data moves mid-low so it never changes while the clock is high
   task automatic bit_io(input logic b, output logic s);
      #(half_ns / 2);
      sda_low = !b;
      #(half_ns / 2);
      scl_low = 1'b0;
      #(half_ns / 2);
      s = sda;
      #(half_ns / 2);
      scl_low = 1'b1;
   endtask
   task automatic stop();
      #(half_ns / 2);
      sda_low = 1'b1;
      #(half_ns / 2);
      scl_low = 1'b0;
      #(half_ns / 2);
      sda_low = 1'b0;
      #(half_ns);
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = !s;
   endtask
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(nack, s);
   endtask
endmodule // cbrs_host_model
`default_nettype wire

//--- verif/cbrs_switch_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Route and pass-through checks
module cbrs_switch_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire cbrs_pkg::cbrs_pair_t ctrl_serial_in,
   input wire cbrs_pkg::cbrs_pair_t ctrl_serial_out,
   input wire cbrs_pkg::cbrs_pair_t ctrl_serial_oe,
   input wire cbrs_pkg::cbrs_pair_t card_rom_in,
   input wire cbrs_pkg::cbrs_pair_t card_rom_out,
   input wire cbrs_pkg::cbrs_pair_t card_rom_oe,
   input wire cbrs_pkg::cbrs_pair_t monitor_bus_in,
   input wire cbrs_pkg::cbrs_pair_t monitor_bus_out,
   input wire cbrs_pkg::cbrs_pair_t monitor_bus_oe,
   input wire cbrs_pkg::cbrs_route_t route
);
   localparam cbrs_pkg::cbrs_route_t ROM = cbrs_pkg::RT_ROM;
   localparam cbrs_pkg::cbrs_route_t REG = cbrs_pkg::RT_REG;
   localparam cbrs_pkg::cbrs_route_t DDC = cbrs_pkg::RT_DDC;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_reset_route: assert property ($fell(sys_rst) |-> route == ROM)
      else $error("route not card ROM after reset");
   a_rom_exit: assert property ($past(route) == ROM && route != ROM
      |-> route == REG && !ctrl_serial_in.clock)
      else $error("card ROM route left wrongly");
   a_reg_exit: assert property ($past(route) == REG && route != REG
      |-> ctrl_serial_in == 2'b11)
      else $error("register route left outside a stop");
   a_ddc_exit: assert property ($past(route) == DDC && route != DDC
      |-> route == REG && ctrl_serial_in == 2'b11)
      else $error("monitor route left wrongly");
   // Allow a few cycles for a driver to let go after a switch
   a_rom_quiet: assert property ((route != ROM)[*6]
      |-> card_rom_oe == 2'b00)
      else $error("card ROM pair driven off route");
   a_mon_quiet: assert property ((route != DDC)[*6]
      |-> monitor_bus_oe == 2'b00)
      else $error("monitor pair driven off route");
   a_open_drain: assert property ({ctrl_serial_out, card_rom_out,
      monitor_bus_out} == 6'h00)
      else $error("open-drain value not low");
   a_rom_fwd: assert property ($fell(ctrl_serial_in.clock)
      && route == ROM |-> ##[1:7] (card_rom_oe.clock || route != ROM))
      else $error("clock low not passed to card ROM");
   a_mon_fwd: assert property ($fell(ctrl_serial_in.clock)
      && route == DDC |-> ##[1:7] (monitor_bus_oe.clock || route != DDC))
      else $error("clock low not passed to monitor");
   a_rom_back: assert property ($fell(card_rom_in.data)
      && !card_rom_oe.data && route == ROM
      |-> ##[1:7] (ctrl_serial_oe.data || route != ROM))
      else $error("card ROM data low not passed back");
   c_to_ddc: cover property (route == DDC);
   c_to_reg: cover property ($past(route) == ROM && route == REG);
   c_ack: cover property (route == REG && ctrl_serial_oe.data);
endmodule // cbrs_switch_chk

bind cbrs_switch cbrs_switch_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .ctrl_serial_in(ctrl_serial_in), .ctrl_serial_out(ctrl_serial_out),
   .ctrl_serial_oe(ctrl_serial_oe), .card_rom_in(card_rom_in),
   .card_rom_out(card_rom_out), .card_rom_oe(card_rom_oe),
   .monitor_bus_in(monitor_bus_in), .monitor_bus_out(monitor_bus_out),
   .monitor_bus_oe(monitor_bus_oe), .route(route));
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {
      logic [7:0] dev;
      logic [7:0] sub;
      logic [7:0] val;
      logic ack;
      cbrs_pkg::cbrs_route_t rt;
   } cbrs_row_t;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic far_pull = 1'b0;
   logic scl_low, sda_low, ack;
   logic [7:0] rd;
   int error_cnt = 0;
   int check_count = 0;
   cbrs_pkg::cbrs_pair_t c_in, c_out, c_oe, r_in, r_out, r_oe;
   cbrs_pkg::cbrs_pair_t m_in, m_out, m_oe;
   cbrs_pkg::cbrs_route_t route;
   cbrs_row_t rows [7] = '{
      '{8'h70, 8'h10, 8'h02, 1'b1, cbrs_pkg::RT_DDC},
      '{8'h70, 8'h10, 8'h02, 1'b0, cbrs_pkg::RT_REG},
      '{8'h72, 8'h10, 8'h06, 1'b1, cbrs_pkg::RT_REG},
      '{8'h72, 8'h10, 8'h01, 1'b1, cbrs_pkg::RT_ROM},
      '{8'h74, 8'h10, 8'h02, 1'b0, cbrs_pkg::RT_ROM},
      '{8'h72, 8'h05, 8'hA5, 1'b1, cbrs_pkg::RT_REG},
      '{8'h70, 8'h12, 8'h5A, 1'b1, cbrs_pkg::RT_REG}};
   always #5 mclk = ~mclk;
   // ======
   // Wired-AND lines with pull-ups
   assign c_in = {~(scl_low | c_oe.clock), ~(sda_low | c_oe.data)};
   assign r_in = {~r_oe.clock, ~(r_oe.data | far_pull)};
   assign m_in = {~m_oe.clock, ~(m_oe.data | far_pull)};
   cbrs_host_model host (.scl(c_in.clock), .sda(c_in.data),
      .scl_low(scl_low), .sda_low(sda_low));
   cbrs_switch dut (.mclk(mclk), .sys_rst(sys_rst),
      .ctrl_serial_in(c_in), .ctrl_serial_out(c_out),
      .ctrl_serial_oe(c_oe), .card_rom_in(r_in), .card_rom_out(r_out),
      .card_rom_oe(r_oe), .monitor_bus_in(m_in), .monitor_bus_out(m_out),
      .monitor_bus_oe(m_oe), .route(route));
   task automatic chk(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] dev, sub, val, input logic ptr,
      output logic a);
      logic a2;
      @(negedge mclk);
      // Slowest rate of the route that the transfer will reach
      host.half_ns = (route == cbrs_pkg::RT_DDC) ? 5000 :
         (route == cbrs_pkg::RT_ROM && dev[7:2] != 6'h1c) ? 1260 : 500;
      host.start();
      host.put_byte(dev, a);
      if (a) begin
         host.put_byte(sub, a2);
         if (!ptr) begin
            host.put_byte(val, a2);
         end
      end
      host.stop();
   endtask
   task automatic rd_reg(input logic [7:0] sub, output logic [7:0] d);
      logic a;
      wr(8'h70, sub, 8'h00, 1'b1, a);
      // Slower controller for the read-backs
      host.half_ns = 800;
      host.start();
      host.put_byte(8'h71, a);
      host.get_byte(1'b1, d);
      host.stop();
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // A full run needs about two thirds of this span
   initial begin
      #800_000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      chk("route", 8'(route), 8'(cbrs_pkg::RT_ROM));
      chk("oe", {2'b00, c_oe, r_oe, m_oe}, 8'h00);
      chk("out", {2'b00, c_out, r_out, m_out}, 8'h00);
      #100 far_pull = 1'b1;
      #100;
      chk("ctrl_oe", 8'(c_oe.data), 8'h01);
      far_pull = 1'b0;
      #200;
      host.start();
      #30;
      chk("rom_oe", 8'(r_oe.clock), 8'h01);
      host.stop();
      foreach (rows[i]) begin
         wr(rows[i].dev, rows[i].sub, rows[i].val, 1'b0, ack);
         chk("ack", 8'(ack), 8'(rows[i].ack));
         chk("route", 8'(route), 8'(rows[i].rt));
      end
      rd_reg(8'h05, rd);
      chk("reg05", rd, 8'hA5);
      rd_reg(8'h12, rd);
      chk("reg12", rd, 8'h00);
      wr(8'h70, 8'h10, 8'h02, 1'b0, ack);
      host.half_ns = 5000;
      host.start();
      #30;
      chk("mon_oe", 8'(m_oe.clock), 8'h01);
      far_pull = 1'b1;
      host.put_byte(8'hA0, ack);
      far_pull = 1'b0;
      chk("mon_ack", 8'(ack), 8'h01);
      host.stop();
      chk("route", 8'(route), 8'(cbrs_pkg::RT_REG));
      @(negedge mclk);
      sys_rst = 1'b1;
      #50;
      sys_rst = 1'b0;
      chk("route", 8'(route), 8'(cbrs_pkg::RT_ROM));
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
